//--- hw/rpmc_pkg.sv
// rpmc_pkg: constants and carrier types for the reset / power-mode controller
// assumes a 200 MHz pclk and an apb slave with 32-bit data
package rpmc_pkg;
  // register byte offsets
  localparam logic [11:0] RPMC_OFS_FEATURE = 12'h000;
  localparam logic [11:0] RPMC_OFS_FONT    = 12'h004;
  localparam logic [11:0] RPMC_OFS_POWER   = 12'h008;
  localparam logic [11:0] RPMC_OFS_BANK    = 12'h00c;
  localparam logic [11:0] RPMC_OFS_XPAGE   = 12'h010;
  localparam logic [11:0] RPMC_OFS_STATUS  = 12'h014;
  // power control fields
  localparam int RPMC_PWR_IDLE_BIT = 0;
  localparam int RPMC_PWR_PD_BIT   = 1;
  localparam int RPMC_BANK_STBY_BIT = 7;
  // feature option fields
  localparam int RPMC_FEAT_LO   = 1;
  localparam int RPMC_FEAT_HI   = 4;
  localparam int RPMC_FEAT_PWM  = 3;
  localparam int RPMC_FONT_SRC  = 4;
  localparam int RPMC_FONT_DST  = 6;
  // reset values
  localparam logic [7:0] RPMC_RST_POWER = 8'h00;
  localparam logic [7:0] RPMC_RST_BANK  = 8'h00;
  localparam logic [7:0] RPMC_RST_XPAGE = 8'h00;
  // timing
  localparam int RPMC_CLK_MHZ       = 200;
  localparam int RPMC_RST_FILT_CLKS = 24;
  localparam int RPMC_RST_HOLD_CLKS = 2048;
  localparam logic [4:0]  RPMC_FILT_MAX = 5'(RPMC_RST_FILT_CLKS - 1);
  localparam logic [11:0] RPMC_HOLD_MAX = 12'(RPMC_RST_HOLD_CLKS - 1);

  typedef enum logic [2:0]
  {
    RPMC_RUN  = 3'b001,
    RPMC_IDLE = 3'b010,
    RPMC_PDN  = 3'b100
  } rpmc_mode_t;

  // section clock enables
  typedef struct packed
  {
    logic cpu;
    logic acq;
    logic disp;
    logic mem;
    logic i2c;
    logic tmr;
    logic wdt;
    logic pwm;
    logic osc;
  } rpmc_gates_t;

  typedef struct packed
  {
    rpmc_mode_t  mode;
    logic [7:0]  power;
    logic [7:0]  bank;
    logic [7:0]  xpage;
    logic [4:0]  filt;
    logic [11:0] hold;
    logic        in_reset;
    logic        rst_s1;
    logic        rst_s2;
    logic        irq_s1;
    logic        irq_s2;
    logic        cmp_s1;
    logic        cmp_s2;
    logic [31:0] prdata;
  } rpmc_state_t;
endpackage

//--- hw/rpmc_top.sv
// rpmc_top: reset sequencing, idle / power-down control, option bits, aux page
// assumes an apb master on pclk; reset and wake pins are asynchronous
//
// Functional notes
// - char rom word 09FE bits 1..4 appear at same feature register bits.
// - feature bit 1 text acquisition, bit 2 caption acquisition available.
// - feature bit 3 routes pwm outputs to port 2.1-2.4, else 3.0-3.3.
// - feature bit 4 one means ten pages, zero six pages.
// - char rom word 09FF bit 4 appears as font register bit 6.
// - unmapped register bits read zero, not the rom reserved ones.
// - external data moves go to on-chip auxiliary memory.
// - page pointer selects one of 256 pages, giving upper address byte.
// - reset recognised only after pin high for 24 clocks.
// - internal reset then held active for 2048 clocks.
// - idle bit enters idle; cpu, acquisition, display clocks gated.
// - idle keeps memory, i2c, timer, watchdog, pwm clocks running.
// - idle freezes cpu, registers, ram and pin values.
// - enabled interrupt clears idle bit and ends idle.
// - analog compare interrupt wakes from idle or power-down.
// - with oscillator running, 24-clock reset pulse completes reset.
// - hardware reset ends low power, restarts at address 0000.
// - power-down bit stops oscillator; ports keep values.
// - power-down loses auxiliary and display memory contents.
// - bank register bit 7 standby disables acquisition and display.
`timescale 1ns/1ps
`default_nettype none
module rpmc_top
  import rpmc_pkg::*;
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] prdata,
  // character rom option words
  input  wire logic [11:0] rom_feature_word,
  input  wire logic [11:0] rom_font_word,
  // pins and wake sources
  input  wire logic        reset_pin,
  input  wire logic        ext_irq_wake,
  input  wire logic        software_adc_compare,
  // cpu side address path
  input  wire logic        external_data_move,
  input  wire logic [7:0]  xdata_addr_lo,
  output logic             aux_ram_sel,
  output logic      [15:0] aux_ram_addr,
  // reset and clock gating outputs
  output logic             internal_reset,
  output logic             pc_restart,
  output rpmc_gates_t      clk_gates,
  output logic             aux_mem_lost,
  output logic             hold_outputs,
  output logic             pwm_on_port2
);

  rpmc_state_t st;
  rpmc_state_t next_st;

  // read-side decode of the option words
  function automatic logic [7:0] feature_view(input logic [11:0] w);
    feature_view = '0;
    feature_view[RPMC_FEAT_HI:RPMC_FEAT_LO] = w[RPMC_FEAT_HI:RPMC_FEAT_LO];
  endfunction

  // address map decode, used only by the error flag; the read mux decodes the offsets on its own
  function automatic logic reg_mapped(input logic [11:0] a);
    reg_mapped = (a == RPMC_OFS_FEATURE) || (a == RPMC_OFS_FONT)
                 || (a == RPMC_OFS_POWER) || (a == RPMC_OFS_BANK)
                 || (a == RPMC_OFS_XPAGE) || (a == RPMC_OFS_STATUS);
  endfunction

  function automatic logic [7:0] font_view(input logic [11:0] w);
    font_view = '0;
    font_view[RPMC_FONT_DST] = w[RPMC_FONT_SRC];
  endfunction

  logic access;
  logic wake;
  assign access = psel & penable;
  // wake by enabled interrupt or analog compare
  assign wake = st.irq_s2 | st.cmp_s2;

  always_comb
  begin
    next_st = st;
    // pin synchronisers
    next_st.rst_s1 = reset_pin;
    next_st.rst_s2 = st.rst_s1;
    next_st.irq_s1 = ext_irq_wake;
    next_st.irq_s2 = st.irq_s1;
    next_st.cmp_s1 = software_adc_compare;
    next_st.cmp_s2 = st.cmp_s1;
    // reset pin filter, also works during idle
    if (!st.rst_s2)
      next_st.filt = '0;
    else if (st.filt != RPMC_FILT_MAX)
      next_st.filt = st.filt + 5'h01;
    // internal reset hold counter
    if (st.rst_s2 && st.filt == RPMC_FILT_MAX && !st.in_reset)
    begin
      next_st.in_reset = 1'b1;
      next_st.hold     = '0;
      next_st.mode     = RPMC_RUN;
      next_st.power    = RPMC_RST_POWER;
      next_st.xpage    = RPMC_RST_XPAGE;
    end
    else if (st.in_reset)
    begin
      if (st.hold == RPMC_HOLD_MAX)
      begin
        if (!st.rst_s2)
          next_st.in_reset = 1'b0;
      end
      else
        next_st.hold = st.hold + 12'h001;
    end
    else
    begin
      // mode sequencing
      unique case (st.mode)
        RPMC_RUN:
        begin
          if (st.power[RPMC_PWR_PD_BIT])
            next_st.mode = RPMC_PDN;
          else if (st.power[RPMC_PWR_IDLE_BIT])
            next_st.mode = RPMC_IDLE;
        end
        RPMC_IDLE:
        begin
          if (wake)
          begin
            next_st.mode = RPMC_RUN;
            next_st.power[RPMC_PWR_IDLE_BIT] = 1'b0;
          end
        end
        RPMC_PDN:
        begin
          if (wake)
          begin
            next_st.mode = RPMC_RUN;
            next_st.power[RPMC_PWR_PD_BIT] = 1'b0;
          end
        end
        default: next_st.mode = RPMC_RUN;
      endcase
      // register writes, cpu frozen outside run
      if (access && pwrite && st.mode == RPMC_RUN)
      begin
        unique case (paddr)
          RPMC_OFS_POWER: next_st.power = pwdata[7:0];
          RPMC_OFS_BANK:  next_st.bank  = pwdata[7:0];
          RPMC_OFS_XPAGE: next_st.xpage = pwdata[7:0];
          default: ;
        endcase
      end
    end
    // read data
    next_st.prdata = '0;
    if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        RPMC_OFS_FEATURE: next_st.prdata = {24'h0, feature_view(rom_feature_word)};
        RPMC_OFS_FONT:    next_st.prdata = {24'h0, font_view(rom_font_word)};
        RPMC_OFS_POWER:   next_st.prdata = {24'h0, st.power};
        RPMC_OFS_BANK:    next_st.prdata = {24'h0, st.bank};
        RPMC_OFS_XPAGE:   next_st.prdata = {24'h0, st.xpage};
        RPMC_OFS_STATUS:  next_st.prdata = {28'h0, st.in_reset, st.mode};
        default:          next_st.prdata = '0;
      endcase
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st          <= '0;
      st.mode     <= RPMC_RUN;
      st.power    <= RPMC_RST_POWER;
      st.bank     <= RPMC_RST_BANK;
      st.xpage    <= RPMC_RST_XPAGE;
      st.in_reset <= 1'b1;
    end
    else
      st <= next_st;
  end

  // apb answers
  assign pready  = 1'b1;
  assign prdata  = st.prdata;
  // unmapped offsets answer with an error in the access phase only
  assign pslverr = access && !reg_mapped(paddr);

  // auxiliary memory address path
  assign aux_ram_sel  = external_data_move;
  assign aux_ram_addr = {st.xpage, xdata_addr_lo};

  // reset outputs
  assign internal_reset = st.in_reset;
  assign pc_restart     = st.in_reset;

  // section clock gating
  always_comb
  begin
    clk_gates      = '1;
    clk_gates.cpu  = (st.mode == RPMC_RUN);
    clk_gates.acq  = (st.mode == RPMC_RUN) && !st.bank[RPMC_BANK_STBY_BIT];
    clk_gates.disp = (st.mode == RPMC_RUN) && !st.bank[RPMC_BANK_STBY_BIT];
    if (st.mode == RPMC_PDN)
      clk_gates = '0;
    // idle keeps memory, i2c, timers, watchdog, pwm running
    if (st.mode == RPMC_IDLE)
    begin
      clk_gates.mem = 1'b1;
      clk_gates.i2c = 1'b1;
      clk_gates.tmr = 1'b1;
      clk_gates.wdt = 1'b1;
      clk_gates.pwm = 1'b1;
      clk_gates.osc = 1'b1;
    end
  end

  // low power side effects
  assign hold_outputs = (st.mode != RPMC_RUN);
  assign aux_mem_lost = (st.mode == RPMC_PDN);
  assign pwm_on_port2 = rom_feature_word[RPMC_FEAT_PWM];

endmodule
`default_nettype wire

//--- sim/rpmc_pins.sv
// rpmc_pins: level model of the reset and wake pins
// assumes commands from tb right after pclk edges
`timescale 1ns/1ps
`default_nettype none
module rpmc_pins (
  // command
  input  wire logic       pclk,
  input  wire logic       go,
  input  wire logic [1:0] sel,
  input  wire logic [7:0] len,
  // pins
  output logic            reset_pin,
  output logic            ext_irq_wake,
  output logic            software_adc_compare
);
  logic [7:0] cnt = '0;
  logic [1:0] s   = '0;
  // hold the chosen line high for len cycles
  always @(posedge pclk)
    if (go)
    begin
      cnt <= len;
      s   <= sel;
    end
    else if (cnt != 8'h00)
      cnt <= cnt - 8'h01;
  // wake lines are levels, not edges
  assign reset_pin            = cnt != 8'h00 && s == 2'h0;
  assign ext_irq_wake         = cnt != 8'h00 && s == 2'h1;
  assign software_adc_compare = cnt != 8'h00 && s == 2'h2;
endmodule
`default_nettype wire

//--- sim/rpmc_top_chk.sv
// rpmc_top_chk: port-level assertions for rpmc_top
// assumes one pclk domain; bound by the statement at the foot
`timescale 1ns/1ps
`default_nettype none
module rpmc_top_chk
  import rpmc_pkg::*;
(
  // clock, reset, apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  // rom words and pins
  input wire logic [11:0] rom_feature_word,
  input wire logic [11:0] rom_font_word,
  input wire logic        reset_pin,
  input wire logic        ext_irq_wake,
  input wire logic        software_adc_compare,
  // outputs under watch
  input wire logic        external_data_move,
  input wire logic [7:0]  xdata_addr_lo,
  input wire logic        aux_ram_sel,
  input wire logic [15:0] aux_ram_addr,
  input wire logic        internal_reset,
  input wire rpmc_gates_t clk_gates,
  input wire logic        aux_mem_lost,
  input wire logic        hold_outputs,
  input wire logic        pwm_on_port2
);
  localparam int HOLD_MIN = 2047;
  logic [11:0] hi_cnt;
  logic [4:0]  pin_cnt;
  wire         rd = psel && penable && !pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // saturating run lengths of reset high and pin high
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      hi_cnt  <= '0;
      pin_cnt <= '0;
    end
    else
    begin
      hi_cnt  <= internal_reset ? hi_cnt + {11'h0, ~&hi_cnt} : 12'h000;
      pin_cnt <= reset_pin ? pin_cnt + {4'h0, ~&pin_cnt} : 5'h00;
    end
  sequence s_irq; ext_irq_wake [*5]; endsequence
  sequence s_adc; software_adc_compare [*5]; endsequence
  property p_feat;
    rd && paddr == RPMC_OFS_FEATURE |-> prdata == {27'h0, rom_feature_word[4:1], 1'b0};
  endproperty
  property p_font;
    rd && paddr == RPMC_OFS_FONT |-> prdata == {25'h0, rom_font_word[4], 6'h00};
  endproperty
  property p_pwm; pwm_on_port2 == rom_feature_word[3]; endproperty
  property p_aux;
    aux_ram_sel == external_data_move && aux_ram_addr[7:0] == xdata_addr_lo;
  endproperty
  property p_idle; hold_outputs && !aux_mem_lost |-> clk_gates == 9'h03f; endproperty
  property p_pd; aux_mem_lost |-> clk_gates == 9'h000 && hold_outputs; endproperty
  property p_hold; $fell(internal_reset) |-> hi_cnt >= HOLD_MIN; endproperty
  property p_filt; $rose(internal_reset) |-> pin_cnt >= 5'h18; endproperty
  property p_wake; s_irq |-> !hold_outputs; endproperty
  property p_adc; s_adc |-> !hold_outputs; endproperty
  a_feat: assert property (p_feat) else $error("feature bits wrong");
  a_font: assert property (p_font) else $error("font bit wrong");
  a_pwm: assert property (p_pwm) else $error("pwm route wrong");
  a_aux: assert property (p_aux) else $error("aux path wrong");
  a_idle: assert property (p_idle) else $error("idle gates wrong");
  a_pd: assert property (p_pd) else $error("power-down gates wrong");
  a_hold: assert property (p_hold) else $error("reset too short");
  a_filt: assert property (p_filt) else $error("reset too early");
  a_wake: assert property (p_wake) else $error("no wake on irq");
  a_adc: assert property (p_adc) else $error("no wake on compare");
endmodule
bind rpmc_top rpmc_top_chk i_rpmc_top_chk (.*);
`default_nettype wire

//--- sim/tb.sv
// tb: table of register accesses, then power-mode and reset cases
// assumes rpmc_pins as pin model and apb zero wait states or more
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rpmc_pkg::*;
  typedef struct packed {logic w; logic [11:0] a; logic [7:0] d, e; logic s;} rpmc_row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, xmv = 0, go = 0;
  logic [11:0] paddr = '0, feat = 12'hff5;
  logic [31:0] pwdata = '0, rdv, prdata;
  logic [7:0] len = '0;
  logic [1:0] sel = '0;
  logic pready, pslverr, errv, rpin, wirq, wadc, ir, pcr, aml, hold, pwm, xsel;
  logic [15:0] xaddr;
  rpmc_gates_t gates;
  int err_total = 0, n_compared = 0, i, k;
  rpmc_row_t rows [11] = '{'{0, 12'h000, 0, 8'h14, 0}, '{0, 12'h004, 0, 8'h40, 0},
    '{0, 12'h008, 0, 8'h00, 0}, '{0, 12'h014, 0, 8'h01, 0}, '{1, 12'h010, 8'ha5, 0, 0},
    '{0, 12'h010, 0, 8'ha5, 0}, '{1, 12'h00c, 8'h80, 0, 0}, '{0, 12'h00c, 0, 8'h80, 0},
    '{1, 12'h000, 8'hff, 0, 0}, '{0, 12'h000, 0, 8'h14, 0}, '{0, 12'h018, 0, 8'h00, 1}};
  always #2.5 pclk = ~pclk;
  rpmc_pins i_rpmc_pins (.pclk(pclk), .go(go), .sel(sel), .len(len), .reset_pin(rpin),
    .ext_irq_wake(wirq), .software_adc_compare(wadc));
  rpmc_top i_rpmc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .rom_feature_word(feat), .rom_font_word(12'hfff), .reset_pin(rpin),
    .ext_irq_wake(wirq), .software_adc_compare(wadc), .external_data_move(xmv),
    .xdata_addr_lo(8'h3c), .aux_ram_sel(xsel), .aux_ram_addr(xaddr), .internal_reset(ir),
    .pc_restart(pcr), .clk_gates(gates), .aux_mem_lost(aml), .hold_outputs(hold),
    .pwm_on_port2(pwm));
  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 64);
    if (k >= 64)
      err_total++;
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // command the pin model
  task pins(input logic [1:0] s, input logic [7:0] n);
    go <= 1'b1;
    sel <= s;
    len <= n;
    @(posedge pclk);
    go <= 1'b0;
  endtask
  // wait while internal reset equals v, bounded
  task wait_ir(input logic v);
    k = 0;
    while (ir === v && k < 3000)
    begin
      @(posedge pclk);
      k++;
    end
  endtask
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #100000;
    err_total++;
    final_report;
  end
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    wait_ir(1'b1);
    chk({31'h0, k >= 2048}, 32'h1);
    for (i = 0; i < 11; i++)
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
        chk({errv, rdv[30:0]}, {rows[i].s, 23'h0, rows[i].e});
    end
    $display("table done");
    xmv <= 1'b1;
    @(posedge pclk);
    @(posedge pclk);
    chk({15'h0, xsel, xaddr}, 32'h0001a53c);
    chk({22'h0, pwm, gates}, 32'h13f);
    feat <= 12'h00a;
    apb(0, RPMC_OFS_FEATURE, 0);
    chk({pwm, rdv[30:0]}, 32'h8000000a);
    // software side: only the idle bit written before idle
    apb(1, RPMC_OFS_POWER, 8'h01);
    repeat (2) @(posedge pclk);
    chk({22'h0, hold, gates}, 32'h23f);
    pins(1, 20);
    repeat (8) @(posedge pclk);
    apb(0, RPMC_OFS_POWER, 0);
    chk({hold, rdv[30:0]}, 32'h0);
    repeat (20) @(posedge pclk);
    apb(1, RPMC_OFS_POWER, 8'h02);
    repeat (2) @(posedge pclk);
    chk({22'h0, aml, gates}, 32'h200);
    pins(2, 20);
    repeat (8) @(posedge pclk);
    chk({22'h0, aml, gates}, 32'h13f);
    repeat (20) @(posedge pclk);
    $display("power modes done");
    pins(0, 10);
    repeat (40) @(posedge pclk);
    chk({31'h0, ir}, 32'h0);
    apb(1, RPMC_OFS_POWER, 8'h01);
    pins(0, 30);
    wait_ir(1'b0);
    chk({30'h0, ir, pcr}, 32'h3);
    wait_ir(1'b1);
    chk({31'h0, k >= 2048}, 32'h1);
    apb(0, RPMC_OFS_XPAGE, 0);
    chk(rdv, 32'h0);
    apb(0, RPMC_OFS_STATUS, 0);
    chk(rdv, 32'h1);
    $display("reset done");
    final_report;
  end
endmodule
`default_nettype wire
